// ---- core/pcgc_pkg.sv ----
// Package for the peripheral clock gate control block.
// Assumes a single 25 MHz bus clock and APB register access.
package pcgc_pkg;

    // ========================================================
    // Sizes and timing
    localparam int NUM_PERIPH = 7;
    localparam int ADDR_W = 12;
    localparam int CLK_PERIOD_NS = 40;
    localparam int INSTR_CYCLE_NS = 80;
    localparam int INSTR_CYCLE_CLKS = INSTR_CYCLE_NS / CLK_PERIOD_NS;

    // ========================================================
    // Register map
    localparam logic [11:0] DISABLE_OFFSET = 12'h000;
    localparam logic [11:0] STATUS_OFFSET = 12'h004;
    localparam logic [15:0] DISABLE_RESET = 16'h0000;
    localparam logic [15:0] DISABLE_WR_MASK = 16'h38a9;
    localparam int STATUS_PEND_BIT = 8;

    // ========================================================
    // Peripheral slots in the internal vectors
    localparam int SLOT_CONVERTER = 0;
    localparam int SLOT_SYNC_SERIAL = 1;
    localparam int SLOT_ASYNC_SERIAL = 2;
    localparam int SLOT_TWO_WIRE = 3;
    localparam int SLOT_TIMER_ONE = 4;
    localparam int SLOT_TIMER_TWO = 5;
    localparam int SLOT_TIMER_THREE = 6;

    // ========================================================
    // Carriers
    typedef struct packed {
        logic [1:0] rsvd_15_14;
        logic timer_three_off;
        logic timer_two_off;
        logic timer_one_off;
        logic [2:0] rsvd_10_8;
        logic two_wire_serial_off;
        logic rsvd_6;
        logic async_serial_off;
        logic rsvd_4;
        logic sync_serial_off;
        logic [1:0] rsvd_2_1;
        logic converter_off;
    } pcgc_disable_t;

    typedef struct packed {
        logic on_req;
        logic wr_req;
        logic rd_req;
    } pcgc_preq_t;

    typedef struct packed {
        logic clk_en;
        logic run;
        logic hold;
        logic wr_en;
        logic rd_ok;
    } pcgc_pgnt_t;

    // Gather disable bits into slot order
    function automatic logic [NUM_PERIPH-1:0] off_vec(pcgc_disable_t r);
        logic [NUM_PERIPH-1:0] v;
        v = '0;
        v[SLOT_CONVERTER] = r.converter_off;
        v[SLOT_SYNC_SERIAL] = r.sync_serial_off;
        v[SLOT_ASYNC_SERIAL] = r.async_serial_off;
        v[SLOT_TWO_WIRE] = r.two_wire_serial_off;
        v[SLOT_TIMER_ONE] = r.timer_one_off;
        v[SLOT_TIMER_TWO] = r.timer_two_off;
        v[SLOT_TIMER_THREE] = r.timer_three_off;
        return v;
    endfunction

endpackage

// ---- core/pcgc_slice.sv ----
// One peripheral's gate: clock enable, run, hold and access gating.
// Assumes off is the applied disable bit, already delayed by the top.
module pcgc_slice (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Control
    input wire logic off,
    input wire logic present,
    input wire pcgc_pkg::pcgc_preq_t req,
    // Grants
    output pcgc_pkg::pcgc_pgnt_t gnt
);

    logic enabled;

    // ========================================================
    // Effective enable
    assign enabled = !off && present; // see [RULE5]

    // ========================================================
    // Registered grants
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gnt <= '0;
        end else begin
            gnt.clk_en <= enabled; // see [RULE1]
            gnt.run <= enabled && req.on_req; // see [RULE8]
            gnt.hold <= !enabled; // see [RULE2]
            gnt.wr_en <= enabled && req.wr_req; // see [RULE3]
            gnt.rd_ok <= enabled && req.rd_req; // see [RULE4]
        end
    end

endmodule

// ---- core/pcgc_top.sv ----
// Peripheral clock gate control: disable register, delayed apply,
// per-peripheral clock gating and register access blocking.
// Assumes an APB master on pclk and peripherals that honour the grants.
//
// Summary of operation
// [RULE1] Set disable bit stops the peripheral's clocks
// [RULE2] Disabled peripheral held in minimum-power state
// [RULE3] Writes to disabled peripheral registers are dropped
// [RULE4] Reads from disabled peripheral are don't-care
// [RULE5] Enabled only when bit clear and present
// [RULE6] All disable bits clear after reset
// [RULE7] Disable takes effect one instruction cycle later
// [RULE8] Enable restarts after one cycle if configured
// [RULE9] Bit value one means off, zero on
// [RULE10] Bits 7, 5, 3: two-wire, async, sync serial
// [RULE11] Bits 13-11 timers three-one, bit 0 converter
// [RULE12] Unused bits ignore writes, read as zero
module pcgc_top (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pcgc_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peripheral side
    input wire logic [pcgc_pkg::NUM_PERIPH-1:0] periph_present,
    input wire pcgc_pkg::pcgc_preq_t [pcgc_pkg::NUM_PERIPH-1:0] periph_req,
    output pcgc_pkg::pcgc_pgnt_t [pcgc_pkg::NUM_PERIPH-1:0] periph_gnt
);

    localparam int N = pcgc_pkg::NUM_PERIPH;
    localparam logic [1:0] APPLY_LOAD =
        2'(pcgc_pkg::INSTR_CYCLE_CLKS - 1);
    localparam int APPLY_DLY = pcgc_pkg::INSTR_CYCLE_CLKS - 1;

    pcgc_pkg::pcgc_disable_t disable_q;
    logic [N-1:0] off_req;
    logic [N-1:0] off_applied_q;
    logic pend_q;
    logic [1:0] cnt_q;
    logic setup;
    logic commit;
    logic hit_disable;
    logic hit_status;
    logic wr_disable;
    logic [15:0] wr_value;
    logic [N-1:0] en_vec;
    logic [N-1:0] clk_vec;
    logic [N-1:0] run_vec;
    logic [N-1:0] wr_vec;
    logic [N-1:0] on_vec;
    logic [N-1:0] wreq_vec;
    logic [31:0] status_word;
    logic [N-1:0] hold_vec;
    logic [N-1:0] rd_vec;
    logic [N-1:0] rreq_vec;

    // ========================================================
    // Bus decode
    assign setup = psel && !penable;
    assign commit = psel && penable && pready;
    assign hit_disable = paddr == pcgc_pkg::DISABLE_OFFSET;
    assign hit_status = paddr == pcgc_pkg::STATUS_OFFSET;
    assign wr_disable = commit && pwrite && hit_disable;

    // Byte lanes merged, then unused bits dropped
    always_comb begin
        wr_value = disable_q;
        if (pstrb[0]) begin
            wr_value[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
            wr_value[15:8] = pwdata[15:8];
        end
        wr_value = wr_value & pcgc_pkg::DISABLE_WR_MASK; // see [RULE12]
    end

    // ========================================================
    // Disable register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            disable_q <= pcgc_pkg::DISABLE_RESET; // see [RULE6]
        end else if (wr_disable) begin
            disable_q <= wr_value; // see [RULE9] [RULE10] [RULE11]
        end
    end

    assign off_req = pcgc_pkg::off_vec(disable_q);

    // ========================================================
    // Delayed apply, one instruction cycle after the write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_q <= 1'b0;
            cnt_q <= 2'h0;
        end else if (wr_disable) begin
            pend_q <= 1'b1; // see [RULE7]
            cnt_q <= APPLY_LOAD;
        end else if (pend_q) begin
            cnt_q <= cnt_q - 2'h1;
            if (cnt_q == 2'h1) begin
                pend_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            off_applied_q <= '0;
        end else if (pend_q && cnt_q == 2'h1) begin
            off_applied_q <= off_req; // see [RULE7] [RULE8]
        end
    end

    // ========================================================
    // Peripheral gates
    for (genvar i = 0; i < N; i++) begin : g_slice
        pcgc_slice u_slice (
            .pclk(pclk),
            .presetn(presetn),
            .off(off_applied_q[i]),
            .present(periph_present[i]),
            .req(periph_req[i]),
            .gnt(periph_gnt[i])
        );
        assign clk_vec[i] = periph_gnt[i].clk_en;
        assign run_vec[i] = periph_gnt[i].run;
        assign wr_vec[i] = periph_gnt[i].wr_en;
        assign on_vec[i] = periph_req[i].on_req;
        assign wreq_vec[i] = periph_req[i].wr_req;
        assign hold_vec[i] = periph_gnt[i].hold;
        assign rd_vec[i] = periph_gnt[i].rd_ok;
        assign rreq_vec[i] = periph_req[i].rd_req;
    end

    assign en_vec = ~off_applied_q & periph_present;

    // ========================================================
    // Status word: live enables and pending apply
    always_comb begin
        status_word = '0;
        status_word[N-1:0] = clk_vec;
        status_word[pcgc_pkg::STATUS_PEND_BIT] = pend_q;
    end

    // ========================================================
    // APB answer: one access cycle, no wait states
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (setup) begin
            pready <= 1'b1;
            pslverr <= !(hit_disable || hit_status);
            if (!pwrite && hit_disable) begin
                prdata <= {16'h0000, 16'(disable_q)}; // see [RULE12]
            end else if (!pwrite && hit_status) begin
                prdata <= status_word;
            end else begin
                prdata <= '0;
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // ========================================================
    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_reserved_zero: assert property ( // see [RULE12]
        (16'(disable_q) & ~pcgc_pkg::DISABLE_WR_MASK) == 16'h0000)
        else $error("reserved disable bits not zero");

    a_apply_not_early: assert property ( // see [RULE7]
        wr_disable |=> off_applied_q == $past(off_applied_q))
        else $error("disable applied in the write cycle");

    a_apply_on_time: assert property ( // see [RULE7]
        (pend_q && cnt_q == 2'h1) |=> off_applied_q == $past(off_req))
        else $error("disable not applied after one instruction cycle");

    a_write_to_apply: assert property ( // see [RULE8]
        (wr_disable ##1 !wr_disable) |->
            ##APPLY_DLY
            off_applied_q == $past(off_req))
        else $error("apply latency differs from one instruction cycle");

    a_clock_gate: assert property ( // see [RULE1]
        presetn |=> clk_vec == $past(en_vec))
        else $error("clock enable does not follow applied enable");

    a_absent_off: assert property ( // see [RULE5]
        ##1 (clk_vec & ~$past(periph_present)) == '0)
        else $error("absent peripheral was clocked");

    a_hold_state: assert property ( // see [RULE2]
        ##1 (run_vec & ~clk_vec) == '0)
        else $error("disabled peripheral still running");

    a_run_needs_on: assert property ( // see [RULE8]
        presetn |=> run_vec == $past(en_vec & on_vec))
        else $error("run does not follow enable and control");

    a_write_block: assert property ( // see [RULE3]
        presetn |=> wr_vec == $past(en_vec & wreq_vec))
        else $error("write reached a disabled peripheral");

    a_read_block: assert property ( // see [RULE4]
        presetn |=> rd_vec == $past(en_vec & rreq_vec))
        else $error("read passed to a disabled peripheral");

    a_hold_inverse: assert property ( // see [RULE2]
        presetn |=> hold_vec == ~clk_vec)
        else $error("hold does not mirror the clock enable");

    a_reset_clear: assert property ( // see [RULE6]
        !$past(presetn) |-> 16'(disable_q) == pcgc_pkg::DISABLE_RESET)
        else $error("disable register not clear after reset");

    a_read_data: assert property ( // see [RULE12]
        (setup && !pwrite && hit_disable) |=>
            prdata == {16'h0000, $past(16'(disable_q))})
        else $error("disable register read back wrong");

    a_other_no_write: assert property (
        (commit && pwrite && !hit_disable) |=> $stable(disable_q))
        else $error("write elsewhere changed the disable register");

    a_bit_map: assert property ( // see [RULE10] [RULE11]
        disable_q[7] == off_req[pcgc_pkg::SLOT_TWO_WIRE]
        && disable_q[13] == off_req[pcgc_pkg::SLOT_TIMER_THREE]
        && disable_q[0] == off_req[pcgc_pkg::SLOT_CONVERTER])
        else $error("disable bit mapped to wrong peripheral");

    a_apb_ready: assert property (
        setup |=> pready ##1 !pready)
        else $error("ready not a single access cycle");

    a_unmapped_err: assert property (
        (setup && !hit_disable && !hit_status) |=> pslverr)
        else $error("unmapped access not flagged");

    c_disable_peripheral: cover property (
        wr_disable && wr_value != 16'h0000 ##[1:4] clk_vec != '1);

    c_reenable: cover property (
        off_applied_q != '0 ##[1:20] wr_disable && wr_value == 16'h0000);

    c_blocked_write: cover property (
        (wreq_vec & ~en_vec) != '0);

    c_back_to_back: cover property (
        wr_disable ##2 wr_disable);

endmodule

// ---- testbench/pcgc_periph_model.sv ----
// Model of one peripheral that sits behind the clock gate.
// Assumes grants from pcgc_top; request levels come from the bench.
module pcgc_periph_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Bench controls
    input wire logic want_on,
    input wire logic want_wr,
    input wire logic want_rd,
    // Gate side
    input wire pcgc_pkg::pcgc_pgnt_t gnt,
    output pcgc_pkg::pcgc_preq_t req,
    output logic [7:0] wr_cnt
);
    timeunit 1ns;
    timeprecision 1ps;

    // ========================================================
    // Requests
    assign req.on_req = want_on;
    assign req.wr_req = want_wr;
    assign req.rd_req = want_rd;

    // ========================================================
    // Register writes land only when granted and clocked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_cnt <= 8'h00;
        end else if (gnt.wr_en && gnt.clk_en) begin
            wr_cnt <= wr_cnt + 8'h01;
        end
    end
endmodule

// ---- testbench/tb_top.sv ----
// Bench for the clock gate: APB tasks and gate checks.
// Assumes one peripheral model per slot.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic pclk, presetn, psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic pready, pslverr, e;
    logic [3:0] strb;
    logic [6:0] present, want_on, want_wr, want_rd;
    pcgc_pkg::pcgc_preq_t [6:0] req;
    pcgc_pkg::pcgc_pgnt_t [6:0] gnt;
    logic [7:0] cnt [7];
    int miscompares = 0;
    int total_checks = 0;
    int bitpos [7] = '{0, 3, 5, 7, 11, 12, 13};

    pcgc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .periph_present(present), .periph_req(req),
        .periph_gnt(gnt));

    for (genvar g = 0; g < 7; g++) begin : g_per
        pcgc_periph_model i_per (.pclk(pclk), .presetn(presetn),
            .want_on(want_on[g]), .want_wr(want_wr[g]),
            .want_rd(want_rd[g]), .gnt(gnt[g]), .req(req[g]),
            .wr_cnt(cnt[g]));
    end

    // ========================================================
    // Helpers
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk(32'h1, 32'h0);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk_gnt(input logic [6:0] en);
        @(posedge pclk);
        #1;
        for (int i = 0; i < 7; i++) begin
            chk(32'(gnt[i].clk_en), 32'(en[i]));
            chk(32'(gnt[i].hold), 32'(!en[i]));
            chk(32'(gnt[i].run), 32'(en[i] & want_on[i]));
        end
    endtask

    task automatic pulse(input int k, input logic ok);
        @(posedge pclk);
        want_wr[k] <= 1'b1;
        want_rd[k] <= 1'b1;
        @(posedge pclk);
        want_wr[k] <= 1'b0;
        want_rd[k] <= 1'b0;
        #1;
        chk(32'(gnt[k].wr_en), 32'(ok));
        chk(32'(gnt[k].rd_ok), 32'(ok));
        @(posedge pclk);
        #1;
    endtask

    task automatic give_verdict();
        if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // ========================================================
    // Clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    initial begin
        repeat (6000) @(posedge pclk);
        miscompares++;
        give_verdict();
    end

    // ========================================================
    // Tests
    initial begin
        {presetn, psel, penable, pwrite} = '0;
        paddr = '0;
        pwdata = '0;
        strb = 4'h3;
        present = 7'h7f;
        want_on = 7'h55;
        want_wr = '0;
        want_rd = '0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        chk(r, 32'h7f);
        chk_gnt(7'h7f);
        for (int k = 0; k < 7; k++) begin
            apb(1'b1, 12'h000, 32'h1 << bitpos[k]);
            chk_gnt(7'h7f);
            chk_gnt(7'h7f & ~(7'h1 << k));
            pulse(k, 1'b0);
            chk(32'(cnt[k]), 32'h0);
            apb(1'b1, 12'h000, 32'h0);
            chk_gnt(7'h7f & ~(7'h1 << k));
            chk_gnt(7'h7f);
            pulse(k, 1'b1);
            chk(32'(cnt[k]), 32'h1);
        end
        apb(1'b1, 12'h000, 32'hffff);
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h38a9);
        chk_gnt(7'h00);
        apb(1'b0, 12'h004, 32'h0);
        chk(r, 32'h0);
        strb <= 4'h1;
        apb(1'b1, 12'h000, 32'h0);
        strb <= 4'h3;
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h3800);
        chk_gnt(7'h0f);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h000, 32'h0);
        chk(r, 32'h0);
        chk_gnt(7'h7f);
        apb(1'b1, 12'h004, 32'hffff);
        chk(32'(e), 32'h0);
        apb(1'b1, 12'h010, 32'h0);
        chk(32'(e), 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        chk(32'(e), 32'h1);
        present <= 7'h7b;
        apb(1'b1, 12'h000, 32'h0);
        chk(32'(e), 32'h0);
        repeat (2) @(posedge pclk);
        chk_gnt(7'h7b);
        pulse(2, 1'b0);
        give_verdict();
    end
endmodule
